/* File: hw/mahb_mac_addr_hash_backoff.v */
// Station address, group hash filter and backoff test logic with an AHB-Lite slave
//
// The placing of the registers and the AHB-Lite slave port were decided locally.
`timescale 1ns/10ps
`include "mahb_consts.vh"
//
// Notes on behaviour
// [R01] Hash bit n is XOR of destination address bits n, n+6, ..., n+42.
// [R02] Hash values 0 to 31 select bits of the low hash table register.
// [R03] Hash values 32 to 63 select bits of the high hash table register.
// [R04] Group frame accepted by hash only when the selected table bit is one.
// [R05] Low address register: byte 0 in bits 15-8, byte 1 in bits 7-0.
// [R06] High address register holds bytes 2,3,4,5 in descending byte lanes.
// [R07] Random generator value reads at bits 25-16 of backoff register.
// [R08] Random generator resets to zero, counts from first edge after reset.
// [R09] Collision count of current frame reads at bits 15-12.
// [R10] Backoff counter loaded after collision, decremented per slot, readable.
// [R11] Address and hash registers are read-write and reset to zero.
// [R12] Backoff register ignores writes; reserved bits read zero.

module mahb_mac_addr_hash_backoff #(
    parameter ATTEMPT_LIMIT = 10
) (
    input  wire        clk_sys,
    input  wire        sys_rst,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire        hreadyout,
    output wire        hresp,
    output reg  [31:0] hrdata,
    input  wire [47:0] rx_dest_addr,
    input  wire        rx_addr_valid,
    output reg         rx_hash_accept,
    output reg  [5:0]  rx_hash_index,
    input  wire        tx_frame_start,
    input  wire        tx_collision,
    input  wire        tx_frame_done,
    input  wire        slot_tick,
    output wire        backoff_active,
    output wire [47:0] station_addr
);

    reg  [15:0] station_addr_low_reg;
    reg  [31:0] station_addr_high_reg;
    reg  [31:0] group_hash_table_low_reg;
    reg  [31:0] group_hash_table_high_reg;
    reg  [9:0]  backoff_random_value_reg;
    reg  [3:0]  frame_collision_tally_reg;
    reg  [9:0]  backoff_slot_counter_reg;
    reg  [9:0]  backoff_slot_counter_next;
    reg         wr_pend_reg;
    reg  [7:0]  wr_ofs_reg;
    reg  [31:0] rd_word;
    reg  [3:0]  tally_next;
    wire        bus_take;
    wire        wr_addr_low;
    wire        wr_addr_high;
    wire        wr_hash_low;
    wire        wr_hash_high;
    wire        tally_saturated;
    wire [5:0]  hash_value;
    wire [9:0]  backoff_mask;
    wire [9:0]  backoff_load;
    wire [31:0] addr_low_word;
    wire [31:0] backoff_word;
    wire [63:0] hash_table;
    wire [7:0]  station_byte_zero;
    wire [7:0]  station_byte_one;
    wire [7:0]  station_byte_two;
    wire [7:0]  station_byte_three;
    wire [7:0]  station_byte_four;
    wire [7:0]  station_byte_five;
    genvar      g;

    // Zero wait states; every transfer gets OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign bus_take  = hsel && hready && (htrans == `MAHB_HTRANS_NONSEQ);

    assign station_byte_zero  = station_addr_low_reg[15:8];   // R05
    assign station_byte_one   = station_addr_low_reg[7:0];    // R05
    assign station_byte_two   = station_addr_high_reg[31:24]; // R06
    assign station_byte_three = station_addr_high_reg[23:16]; // R06
    assign station_byte_four  = station_addr_high_reg[15:8];  // R06
    assign station_byte_five  = station_addr_high_reg[7:0];   // R06
    assign station_addr = {station_byte_five, station_byte_four, station_byte_three,
                           station_byte_two, station_byte_one, station_byte_zero};

    // Low half of the table answers 0-31, high half 32-63
    assign hash_table = {group_hash_table_high_reg, group_hash_table_low_reg}; // R02 R03

    // One XOR tree per hash bit; each folds every sixth address bit
    generate
        for (g = 0; g < 6; g = g + 1) begin : g_hash_bit
            assign hash_value[g] = rx_dest_addr[g]      ^ rx_dest_addr[g + 6]  ^
                                   rx_dest_addr[g + 12] ^ rx_dest_addr[g + 18] ^
                                   rx_dest_addr[g + 24] ^ rx_dest_addr[g + 30] ^
                                   rx_dest_addr[g + 36] ^ rx_dest_addr[g + 42]; // R01
        end
    endgenerate

    always @(posedge clk_sys) begin
        if (sys_rst) begin
            rx_hash_accept <= 1'b0;
            rx_hash_index  <= 6'h00;
        end else if (rx_addr_valid) begin
            rx_hash_index  <= hash_value;
            // Only group addresses can pass; bit 0 of the destination address is ANDed in here
            rx_hash_accept <= rx_dest_addr[0] & hash_table[hash_value]; // R04
        end
    end

    // Writes land in the data phase, offset captured in the address phase
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            wr_pend_reg <= 1'b0;
            wr_ofs_reg  <= 8'h00;
        end else if (hready) begin
            wr_pend_reg <= bus_take && hwrite;
            wr_ofs_reg  <= haddr[7:0];
        end
    end

    assign wr_addr_low  = wr_pend_reg && (wr_ofs_reg == `MAHB_OFS_ADDR_LOW);
    assign wr_addr_high = wr_pend_reg && (wr_ofs_reg == `MAHB_OFS_ADDR_HIGH);
    assign wr_hash_low  = wr_pend_reg && (wr_ofs_reg == `MAHB_OFS_HASH_LOW);
    assign wr_hash_high = wr_pend_reg && (wr_ofs_reg == `MAHB_OFS_HASH_HIGH);
    // No enable decodes the backoff offset, so writes there fall away
    // R12

    always @(posedge clk_sys) begin
        if (sys_rst) begin
            station_addr_low_reg <= `MAHB_RST_LOW_HALF; // R11
        end else if (wr_addr_low) begin
            station_addr_low_reg <= hwdata[15:0];       // R11
        end
    end

    always @(posedge clk_sys) begin
        if (sys_rst) begin
            station_addr_high_reg <= `MAHB_RST_WORD; // R11
        end else if (wr_addr_high) begin
            station_addr_high_reg <= hwdata;         // R11
        end
    end

    always @(posedge clk_sys) begin
        if (sys_rst) begin
            group_hash_table_low_reg <= `MAHB_RST_WORD; // R11
        end else if (wr_hash_low) begin
            group_hash_table_low_reg <= hwdata;         // R11
        end
    end

    always @(posedge clk_sys) begin
        if (sys_rst) begin
            group_hash_table_high_reg <= `MAHB_RST_WORD; // R11
        end else if (wr_hash_high) begin
            group_hash_table_high_reg <= hwdata;         // R11
        end
    end

    // Reserved bits are tied to zero in the read words
    assign addr_low_word = {`MAHB_RST_LOW_HALF, station_addr_low_reg};          // R12
    assign backoff_word  = {6'h00, backoff_random_value_reg,                    // R07
                            frame_collision_tally_reg,                          // R09
                            2'h0, backoff_slot_counter_reg};                    // R10 R12

    always @* begin
        rd_word = `MAHB_RST_WORD;
        case (haddr[7:0])
            `MAHB_OFS_ADDR_LOW: begin
                rd_word = addr_low_word;                // R05
            end
            `MAHB_OFS_ADDR_HIGH: begin
                rd_word = station_addr_high_reg;        // R06
            end
            `MAHB_OFS_HASH_LOW: begin
                rd_word = group_hash_table_low_reg;     // R02
            end
            `MAHB_OFS_HASH_HIGH: begin
                rd_word = group_hash_table_high_reg;    // R03
            end
            `MAHB_OFS_BACKOFF: begin
                rd_word = backoff_word;                 // R07
            end
            default: begin
                rd_word = `MAHB_RST_WORD;               // R12
            end
        endcase
    end

    always @(posedge clk_sys) begin
        if (sys_rst) begin
            hrdata <= `MAHB_RST_WORD;
        end else if (bus_take && !hwrite) begin
            hrdata <= rd_word;
        end
    end

    // Free-running generator; its value matters when a collision samples it or the backoff register is read
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            backoff_random_value_reg <= `MAHB_RST_TEN;                              // R08
        end else begin
            backoff_random_value_reg <= backoff_random_value_reg + 10'h001;        // R08
        end
    end

    assign tally_saturated = (frame_collision_tally_reg == 4'hf);

    // Count stops at fifteen rather than wrapping back to zero
    always @* begin
        tally_next = frame_collision_tally_reg;
        if (tx_collision && !tally_saturated) begin
            tally_next = frame_collision_tally_reg + 4'h1;
        end
    end

    // Window doubles per collision until the attempt limit caps it
    generate
        for (g = 0; g < 10; g = g + 1) begin : g_mask_bit
            assign backoff_mask[g] = (g < tally_next) && (g < ATTEMPT_LIMIT);
        end
    endgenerate

    assign backoff_load = backoff_random_value_reg & backoff_mask; // R10

    // Frame start wins over a stale tally; a same-cycle collision counts as 1, but its backoff mask uses tally_next of the stale count
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            frame_collision_tally_reg <= `MAHB_RST_TALLY;
        end else if (tx_frame_start || tx_frame_done) begin
            frame_collision_tally_reg <= tx_collision ? 4'h1 : `MAHB_RST_TALLY; // R09
        end else begin
            frame_collision_tally_reg <= tally_next;                            // R09
        end
    end

    // Collision load wins over a slot tick in the same cycle
    always @* begin
        backoff_slot_counter_next = backoff_slot_counter_reg;
        if (tx_collision) begin
            backoff_slot_counter_next = backoff_load;                              // R10
        end else if (slot_tick && backoff_slot_counter_reg != 10'h000) begin
            backoff_slot_counter_next = backoff_slot_counter_reg - 10'h001;       // R10
        end
    end

    always @(posedge clk_sys) begin
        if (sys_rst) begin
            backoff_slot_counter_reg <= `MAHB_RST_TEN;
        end else begin
            backoff_slot_counter_reg <= backoff_slot_counter_next;                // R10
        end
    end

    assign backoff_active = (backoff_slot_counter_reg != 10'h000);

endmodule // mahb_mac_addr_hash_backoff

/* File: hw/mahb_consts.vh */
// Register offsets, field positions and reset values for the address, hash and backoff block
`ifndef MAHB_CONSTS_VH
`define MAHB_CONSTS_VH

`define MAHB_OFS_ADDR_LOW   8'h00
`define MAHB_OFS_ADDR_HIGH  8'h04
`define MAHB_OFS_HASH_LOW   8'h08
`define MAHB_OFS_HASH_HIGH  8'h0c
`define MAHB_OFS_BACKOFF    8'h10

`define MAHB_RST_WORD       32'h0000_0000
`define MAHB_RST_LOW_HALF   16'h0000
`define MAHB_RST_TEN        10'h000
`define MAHB_RST_TALLY      4'h0

`define MAHB_RND_LSB        16
`define MAHB_RND_MSB        25
`define MAHB_TALLY_LSB      12
`define MAHB_TALLY_MSB      15
`define MAHB_SLOT_LSB       0
`define MAHB_SLOT_MSB       9

`define MAHB_HTRANS_NONSEQ  2'h2

`endif

/* File: testbench/mahb_asserts.sv */
// Port checker for bus reads, hash filter and backoff
`timescale 1ns/10ps
module mahb_asserts (
    input wire        clk_sys,
    input wire        sys_rst,
    input wire        hsel,
    input wire [31:0] haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire        hready,
    input wire [31:0] hrdata,
    input wire [47:0] rx_dest_addr,
    input wire        rx_addr_valid,
    input wire        rx_hash_accept,
    input wire [5:0]  rx_hash_index,
    input wire        tx_collision,
    input wire        backoff_active,
    input wire [47:0] station_addr
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    wire [47:0] a = rx_dest_addr;
    wire [47:0] s = station_addr;
    wire [5:0]  h = a[5:0]^a[11:6]^a[17:12]^a[23:18]^a[29:24]^a[35:30]^a[41:36]^a[47:42];
    wire [31:0] lo = {16'h0, s[7:0], s[15:8]};
    wire [31:0] hi = {s[23:16], s[31:24], s[39:32], s[47:40]};
    wire        rd = hsel && hready && htrans == 2'h2 && !hwrite;
    chk_hash_index: assert property (rx_addr_valid |=> rx_hash_index == $past(h))
        else $error("bad index");
    chk_group_bit: assert property (rx_addr_valid && !a[0] |=> !rx_hash_accept)
        else $error("bad accept");
    chk_hash_hold: assert property (!rx_addr_valid |=> $stable(rx_hash_accept))
        else $error("accept moved");
    chk_low_read: assert property (rd && haddr[7:0] == 8'h00 |=> hrdata == $past(lo))
        else $error("bad low word");
    chk_high_read: assert property (rd && haddr[7:0] == 8'h04 |=> hrdata == $past(hi))
        else $error("bad high word");
    chk_test_rsvd: assert property (rd && haddr[7:0] == 8'h10 |=> hrdata[31:26] == 6'h0)
        else $error("reserved set");
    chk_unmapped_zero: assert property (rd && haddr[7:0] == 8'h14 |=> hrdata == 32'h0)
        else $error("unmapped data");
    chk_idle_slot: assert property (!backoff_active && !tx_collision |=> !backoff_active)
        else $error("backoff started");
endmodule // mahb_asserts
bind mahb_mac_addr_hash_backoff mahb_asserts i_chk (.*);

/* File: testbench/mahb_net_model.sv */
// Network side model: received addresses and transmit events
`timescale 1ns/10ps
module mahb_net_model (
    input  wire         clk_sys,
    output logic [47:0] rx_dest_addr = 48'h0,
    output logic        rx_addr_valid = 1'b0,
    output logic [3:0]  tx_ev = 4'h0
);
    // Released address shows its inverse so stale bits cannot match
    task rx(input logic [47:0] d);
        rx_dest_addr <= d;
        rx_addr_valid <= 1'b1;
        @(posedge clk_sys);
        rx_addr_valid <= 1'b0;
        rx_dest_addr <= ~d;
        @(posedge clk_sys);
    endtask
    task ev(input logic [3:0] m);
        tx_ev <= m;
        @(posedge clk_sys);
        tx_ev <= 4'h0;
        @(posedge clk_sys);
    endtask
endmodule // mahb_net_model

/* File: testbench/tb_mac_addr_hash_backoff.sv */
// Self-checking bench for station address, hash filter and backoff
`timescale 1ns/10ps
module tb_mac_addr_hash_backoff;
    logic        clk_sys = 0, sys_rst = 1, hsel = 0, hwrite = 0, hready;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q, r;
    logic        hreadyout, hresp, rx_hash_accept, rx_addr_valid, backoff_active;
    logic [3:0]  tx_ev;
    logic [5:0]  rx_hash_index;
    logic [47:0] rx_dest_addr, station_addr;
    int          err_total = 0, num_checks = 0;
    logic [71:0] rows [5] = '{{8'h00, 32'hffff1234, 32'h00001234},
        {8'h04, 32'h12345678, 32'h12345678}, {8'h08, 32'hf0f0f003, 32'hf0f0f003},
        {8'h0c, 32'h5a5a5a5a, 32'h5a5a5a5a}, {8'h14, 32'hffffffff, 32'h0}};
    logic [54:0] hrow [7] = '{{48'h000000000001, 6'h01, 1'b1},
        {48'h800000000001, 6'h21, 1'b1}, {48'h000000000003, 6'h03, 1'b0},
        {48'h000000000040, 6'h01, 1'b0}, {48'h040000000001, 6'h00, 1'b1},
        {48'h800000000005, 6'h25, 1'b0}, {48'h000008000001, 6'h09, 1'b0}};
    assign hready = hreadyout;
    always #12.5 clk_sys = ~clk_sys;
    mahb_mac_addr_hash_backoff i_dut (.*, .tx_frame_start(tx_ev[3]), .tx_collision(tx_ev[2]),
        .tx_frame_done(tx_ev[1]), .slot_tick(tx_ev[0]));
    mahb_net_model i_net (.*);
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] o);
        hsel <= 1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        hsel <= 0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        o = hrdata;
    endtask
    task chk(input string n, input logic [63:0] e, input logic [63:0] s);
        num_checks++;
        if (s !== e) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", n, e, s);
        end
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk_sys);
        sys_rst <= 0;
        xfer(0, 8'h10, 0, q);
        chk("backoff at reset", 0, q);
        foreach (rows[i]) begin
            xfer(0, rows[i][71:64], 0, q);
            chk("reset value", 0, q);
            xfer(1, rows[i][71:64], rows[i][63:32], q);
            xfer(0, rows[i][71:64], 0, q);
            chk("read back", rows[i][31:0], q);
        end
        chk("station", 48'h785634123412, station_addr);
        chk("response", 0, hresp);
        $display("register test done");
        foreach (hrow[i]) begin
            i_net.rx(hrow[i][54:7]);
            chk("hash index", hrow[i][6:1], rx_hash_index);
            chk("accept", hrow[i][0], rx_hash_accept);
        end
        $display("hash test done");
        xfer(0, 8'h10, 0, q);
        xfer(0, 8'h10, 0, r);
        chk("random step", q[25:16] + 2, r[25:16]);
        i_net.ev(4'h8);
        repeat (3) i_net.ev(4'h4);
        xfer(1, 8'h10, 32'hffffffff, q);
        xfer(0, 8'h10, 0, q);
        chk("tally", 3, q[15:12]);
        chk("slot bound", 1, q[9:0] <= 10'h7);
        chk("active", q[9:0] != 0, backoff_active);
        i_net.ev(4'h1);
        xfer(0, 8'h10, 0, r);
        chk("slot step", (q[9:0] == 0) ? 0 : q[9:0] - 1, r[9:0]);
        repeat (7) i_net.ev(4'h1);
        chk("idle", 0, backoff_active);
        i_net.ev(4'h2);
        xfer(0, 8'h10, 0, q);
        chk("tally cleared", 0, {q[15:10], q[9:0]});
        i_net.ev(4'hc);
        xfer(0, 8'h10, 0, q);
        chk("start with hit", 1, q[15:12]);
        $display("backoff test done");
        sys_rst <= 1;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 0;
        xfer(0, 8'h10, 0, q);
        chk("backoff after reset", 0, q);
        xfer(0, 8'h00, 0, q);
        chk("address after reset", 0, q);
        $display("reset test done");
        stop_test;
    end
    initial begin
        repeat (2000) @(posedge clk_sys);
        err_total++;
        stop_test;
    end
endmodule // tb_mac_addr_hash_backoff
